// ==== design/pfc_pkg.sv ====
package pfc_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OFS_TRIP_SEL = 8'h00;
    localparam logic [7:0] OFS_QUAL_CFG = 8'h04;
    localparam logic [7:0] OFS_FILT_CFG = 8'h08;
    localparam logic [7:0] OFS_TRIP_ACT = 8'h0C;
    localparam logic [7:0] OFS_BLOCK_EN = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;

    // ----------------------------------------------------------------
    // Widths and field positions
    // ----------------------------------------------------------------
    localparam int SRC_N  = 4;
    localparam int EVT_N  = 4;
    localparam int QCFG_W = 3;
    localparam int FILT_W = 8;
    localparam int ACT_W  = 2;
    localparam int CNT_W  = 16;
    localparam int BEN_OST_LSB = 4;
    localparam int BEN_ADC_BIT = 8;
    localparam int ST_CBC_BIT  = 0;
    localparam int ST_OST_BIT  = 1;
    localparam int ST_FRC_LSB  = 2;
    localparam int ST_BLK_BIT  = 6;

    // ----------------------------------------------------------------
    // Reset values and encodings
    // ----------------------------------------------------------------
    localparam logic [15:0]       RST_TRIP_SEL = 16'h0000;
    localparam logic [11:0]       RST_QUAL_CFG = 12'h000;
    localparam logic [FILT_W-1:0] RST_FILT_CFG = 8'h00;
    localparam logic [15:0]       RST_TRIP_ACT = 16'h0000;
    localparam logic [8:0]        RST_BLOCK_EN = 9'h000;
    localparam logic [CNT_W-1:0]  TB_ZERO      = 16'h0000;

    localparam logic [QCFG_W-1:0] QC_OFF       = 3'h0;
    localparam logic [QCFG_W-1:0] QC_LO_LOW    = 3'h1;
    localparam logic [QCFG_W-1:0] QC_LO_HIGH   = 3'h2;
    localparam logic [QCFG_W-1:0] QC_HI_LOW    = 3'h3;
    localparam logic [QCFG_W-1:0] QC_HI_HIGH   = 3'h4;
    localparam logic [QCFG_W-1:0] QC_LOL_HIH   = 3'h5;
    localparam logic [QCFG_W-1:0] QC_LOH_HIL   = 3'h6;
    localparam logic [QCFG_W-1:0] QC_BOTH_HIGH = 3'h7;

    localparam logic [ACT_W-1:0] NO_ACTION_SETTING = 2'h0;
    localparam logic [1:0]       RESP_OKAY         = 2'h0;
    localparam logic [1:0]       RESP_SLVERR       = 2'h2;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic chan_b_low_line;
        logic chan_b_high_line;
        logic chan_a_low_line;
        logic chan_a_high_line;
    } pfc_lines_s;

    // Bit 0 channel A event 0, 1 A event 1, 2 B event 0, 3 B event 1
    typedef struct packed {
        logic b_ev1;
        logic b_ev0;
        logic a_ev1;
        logic a_ev0;
    } pfc_evt_s;

endpackage

// ==== design/pfc_qual_unit.sv ====
`timescale 1ns/100ps
`default_nettype none

module pfc_qual_unit
    import pfc_pkg::*;
(
    // Compare lines of one channel
    input  wire logic              high_line,
    input  wire logic              low_line,
    // Qualifier configuration per event
    input  wire logic [QCFG_W-1:0] qualifier_config0,
    input  wire logic [QCFG_W-1:0] qualifier_config1,
    // Raw events
    output logic                   raw_event0,
    output logic                   raw_event1
);

    function automatic logic qualify(input logic [QCFG_W-1:0] cfg, input logic h,
                                     input logic l);
        logic r;
        r = 1'b0;
        unique case (cfg)
            QC_OFF:       r = 1'b0;
            QC_LO_LOW:    r = ~l;
            QC_LO_HIGH:   r = l;
            QC_HI_LOW:    r = ~h;
            QC_HI_HIGH:   r = h;
            QC_LOL_HIH:   r = ~l & h;
            QC_LOH_HIL:   r = l & ~h;
            QC_BOTH_HIGH: r = l & h;
        endcase
        return r;
    endfunction

    // ----------------------------------------------------------------
    // Qualification
    // ----------------------------------------------------------------
    assign raw_event0 = qualify(qualifier_config0, high_line, low_line);
    assign raw_event1 = qualify(qualifier_config1, high_line, low_line);

endmodule

`default_nettype wire

// ==== design/pfc_trip.sv ====
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Comparator high and low threshold outputs pass through the fault-compare stage to four forced trip signals that feed per-cycle or one-shot blocking.
// - A forced signal whose action setting in either trip action control is not no-action goes straight to the arbitrator, bypassing both blocking latches.
// - Each of the four compare lines is the OR of the input events picked by its trip-select mask.
// - Two qualifier units, one per channel, combine that channel's high and low lines into raw events 0 and 1.
// - Qualifier code 0 disables, 1 low low, 2 low high, 3 high low, 4 high high, 5 low low and high high, 6 low high and high low, 7 both high.
// - Raw events pass a window filter before event processing makes the final outputs.
// - Each final event yields both a forced trip signal and an interrupt request.
// - In up-down counting an ADC start request is raised when the time-base count reaches 0, one request for all channels.
// - When one-shot and per-cycle blocking coincide, one-shot takes precedence.
// - Per-cycle blocking holds while an enabled force is present and releases at the first period start without one.
// - One-shot blocking latches until software clears the one-shot flag.
module pfc_trip
    import pfc_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Trip sources from pins and comparators
    input  wire logic              comparator_high_threshold_out,
    input  wire logic              comparator_low_threshold_out,
    input  wire logic [1:0]        ext_trip_in,
    // Time base, same clock
    input  wire logic [CNT_W-1:0]  time_base_count,
    input  wire logic              updown_mode,
    // Forced trip signals and interrupt requests
    output logic                   chan_a_event0_trip_force,
    output logic                   chan_a_event1_trip_force,
    output logic                   chan_b_event0_trip_force,
    output logic                   chan_b_event1_trip_force,
    output logic                   chan_a_event0_irq,
    output logic                   chan_a_event1_irq,
    output logic                   chan_b_event0_irq,
    output logic                   chan_b_event1_irq,
    // Arbitrator and blocking
    output logic                   arb_direct_a,
    output logic                   arb_direct_b,
    output logic                   per_cycle_block,
    output logic                   one_shot_block,
    output logic                   trip_block,
    output logic                   trip_block_one_shot,
    // ADC start
    output logic                   adc_start_req
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0]       trip_input_select;
    logic [11:0]       qual_cfg;
    logic [FILT_W-1:0] filt_len;
    logic [15:0]       trip_act;
    logic [8:0]        block_en;

    logic [ADDR_W-1:0] aw_addr;
    logic              aw_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              w_full;
    logic              do_write;
    logic              next_aw_full;
    logic              next_w_full;
    logic              next_rvalid;
    logic              ost_clear;
    logic [31:0]       rd_word;
    logic              rd_hit;
    logic              wr_hit;

    pfc_evt_s          force_q;
    pfc_evt_s          raw_ev;
    pfc_evt_s          filt_ev;
    pfc_lines_s        lines;
    logic [SRC_N-1:0]  src_meta;
    logic [SRC_N-1:0]  src_sync;
    logic [CNT_W-1:0]  tb_prev;
    logic              cbc_set;
    logic              ost_set;
    logic              period_start;
    logic [EVT_N-1:0]  routed;
    logic              next_one_shot;
    logic              next_per_cycle;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ----------------------------------------------------------------
    // AXI4-Lite slave
    // ----------------------------------------------------------------
    assign do_write     = aw_full & w_full & ~s_axi_bvalid;
    assign next_aw_full = (aw_full | (s_axi_awvalid & s_axi_awready)) & ~do_write;
    assign next_w_full  = (w_full | (s_axi_wvalid & s_axi_wready)) & ~do_write;
    assign next_rvalid  = (s_axi_rvalid & ~s_axi_rready) | (s_axi_arvalid & s_axi_arready);

    always_comb begin
        wr_hit = 1'b1;
        unique case ({aw_addr[ADDR_W-1:2], 2'b00})
            OFS_TRIP_SEL, OFS_QUAL_CFG, OFS_FILT_CFG,
            OFS_TRIP_ACT, OFS_BLOCK_EN, OFS_STATUS: wr_hit = 1'b1;
            default:                                wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full       <= 1'b0;
            w_full        <= 1'b0;
            aw_addr       <= '0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            aw_full       <= next_aw_full;
            w_full        <= next_w_full;
            s_axi_awready <= ~next_aw_full;
            s_axi_wready  <= ~next_w_full;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Configuration writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_input_select <= RST_TRIP_SEL;
            qual_cfg          <= RST_QUAL_CFG;
            filt_len          <= RST_FILT_CFG;
            trip_act          <= RST_TRIP_ACT;
            block_en          <= RST_BLOCK_EN;
        end else if (do_write) begin
            unique case ({aw_addr[ADDR_W-1:2], 2'b00})
                OFS_TRIP_SEL: trip_input_select <= 16'(merge({16'h0000, trip_input_select},
                                                         w_data, w_strb));
                OFS_QUAL_CFG: qual_cfg <= 12'(merge({20'h00000, qual_cfg}, w_data, w_strb));
                OFS_FILT_CFG: filt_len <= FILT_W'(merge({24'h000000, filt_len}, w_data,
                                                w_strb));
                OFS_TRIP_ACT: trip_act <= 16'(merge({16'h0000, trip_act}, w_data, w_strb));
                OFS_BLOCK_EN: block_en <= 9'(merge({23'h000000, block_en}, w_data, w_strb));
                default: ;
            endcase
        end
    end

    // Writing one to the one-shot status bit releases the latch
    assign ost_clear = do_write && ({aw_addr[ADDR_W-1:2], 2'b00} == OFS_STATUS)
                       && w_strb[0] && w_data[ST_OST_BIT];

    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        unique case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
            OFS_TRIP_SEL: rd_word[15:0]       = trip_input_select;
            OFS_QUAL_CFG: rd_word[11:0]       = qual_cfg;
            OFS_FILT_CFG: rd_word[FILT_W-1:0] = filt_len;
            OFS_TRIP_ACT: rd_word[15:0]       = trip_act;
            OFS_BLOCK_EN: rd_word[8:0]        = block_en;
            OFS_STATUS: begin
                rd_word[ST_CBC_BIT]                 = per_cycle_block;
                rd_word[ST_OST_BIT]                 = one_shot_block;
                rd_word[ST_FRC_LSB +: EVT_N]        = force_q;
                rd_word[ST_BLK_BIT]                 = trip_block;
            end
            default:      rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_rvalid  <= next_rvalid;
            s_axi_arready <= ~next_rvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ----------------------------------------------------------------
    // Input synchronisers and trip selection
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_meta <= '0;
            src_sync <= '0;
        end else begin
            src_meta <= {ext_trip_in, comparator_low_threshold_out,
                         comparator_high_threshold_out};
            src_sync <= src_meta;
        end
    end

    assign lines.chan_a_high_line = |(trip_input_select[3:0]   & src_sync);
    assign lines.chan_a_low_line  = |(trip_input_select[7:4]   & src_sync);
    assign lines.chan_b_high_line = |(trip_input_select[11:8]  & src_sync);
    assign lines.chan_b_low_line  = |(trip_input_select[15:12] & src_sync);

    // ----------------------------------------------------------------
    // Qualifiers, one per channel
    // ----------------------------------------------------------------
    pfc_qual_unit u_qual_a (
        .high_line         (lines.chan_a_high_line),
        .low_line          (lines.chan_a_low_line),
        .qualifier_config0 (qual_cfg[2:0]),
        .qualifier_config1 (qual_cfg[5:3]),
        .raw_event0        (raw_ev.a_ev0),
        .raw_event1        (raw_ev.a_ev1)
    );

    pfc_qual_unit u_qual_b (
        .high_line         (lines.chan_b_high_line),
        .low_line          (lines.chan_b_low_line),
        .qualifier_config0 (qual_cfg[8:6]),
        .qualifier_config1 (qual_cfg[11:9]),
        .raw_event0        (raw_ev.b_ev0),
        .raw_event1        (raw_ev.b_ev1)
    );

    // ----------------------------------------------------------------
    // Window filter and event processing
    // ----------------------------------------------------------------
    // An event passes only after staying high for filt_len + 1 cycles, so
    // comparator glitches shorter than that never reach the trip logic.
    for (genvar g = 0; g < EVT_N; g++) begin : g_evt
        logic [FILT_W-1:0] win_cnt;
        assign routed[g] = trip_act[g*ACT_W +: ACT_W] == NO_ACTION_SETTING
                           && trip_act[8 + g*ACT_W +: ACT_W] == NO_ACTION_SETTING;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                win_cnt    <= '0;
                filt_ev[g] <= 1'b0;
            end else if (!raw_ev[g]) begin
                win_cnt    <= '0;
                filt_ev[g] <= 1'b0;
            end else begin
                if (win_cnt != filt_len) begin
                    win_cnt <= win_cnt + 1'b1;
                end
                filt_ev[g] <= (win_cnt == filt_len);
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            force_q           <= '0;
            chan_a_event0_irq <= 1'b0;
            chan_a_event1_irq <= 1'b0;
            chan_b_event0_irq <= 1'b0;
            chan_b_event1_irq <= 1'b0;
        end else begin
            force_q           <= filt_ev;
            chan_a_event0_irq <= filt_ev.a_ev0 & ~force_q.a_ev0;
            chan_a_event1_irq <= filt_ev.a_ev1 & ~force_q.a_ev1;
            chan_b_event0_irq <= filt_ev.b_ev0 & ~force_q.b_ev0;
            chan_b_event1_irq <= filt_ev.b_ev1 & ~force_q.b_ev1;
        end
    end

    assign chan_a_event0_trip_force = force_q.a_ev0;
    assign chan_a_event1_trip_force = force_q.a_ev1;
    assign chan_b_event0_trip_force = force_q.b_ev0;
    assign chan_b_event1_trip_force = force_q.b_ev1;

    // ----------------------------------------------------------------
    // Direct arbitrator path and blocking
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arb_direct_a <= 1'b0;
            arb_direct_b <= 1'b0;
        end else begin
            arb_direct_a <= 1'b0;
            arb_direct_b <= 1'b0;
            for (int i = 0; i < EVT_N; i++) begin
                if (filt_ev[i] && trip_act[i*ACT_W +: ACT_W] != NO_ACTION_SETTING) begin
                    arb_direct_a <= 1'b1;
                end
                if (filt_ev[i] && trip_act[8 + i*ACT_W +: ACT_W] != NO_ACTION_SETTING) begin
                    arb_direct_b <= 1'b1;
                end
            end
        end
    end

    // Forces with an action set bypass both latches
    assign cbc_set      = |(force_q & routed & block_en[EVT_N-1:0]);
    assign ost_set      = |(force_q & routed & block_en[BEN_OST_LSB +: EVT_N]);
    assign period_start = (time_base_count == TB_ZERO) && (tb_prev != TB_ZERO);

    always_comb begin
        next_per_cycle = per_cycle_block;
        if (cbc_set) begin
            next_per_cycle = 1'b1;
        end else if (period_start) begin
            next_per_cycle = 1'b0;
        end
        next_one_shot = one_shot_block;
        if (ost_set) begin
            next_one_shot = 1'b1;
        end else if (ost_clear) begin
            next_one_shot = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            per_cycle_block     <= 1'b0;
            one_shot_block      <= 1'b0;
            trip_block          <= 1'b0;
            trip_block_one_shot <= 1'b0;
        end else begin
            per_cycle_block     <= next_per_cycle;
            one_shot_block      <= next_one_shot;
            trip_block          <= next_per_cycle | next_one_shot;
            trip_block_one_shot <= next_one_shot;
        end
    end

    // ----------------------------------------------------------------
    // ADC start on counter zero
    // ----------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tb_prev       <= TB_ZERO;
            adc_start_req <= 1'b0;
        end else begin
            tb_prev       <= time_base_count;
            adc_start_req <= updown_mode && block_en[BEN_ADC_BIT] && period_start;
        end
    end

endmodule

`default_nettype wire

// ==== sim/pfc_comp_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module pfc_comp_model
    import pfc_pkg::*;
#(
    parameter logic [11:0] HI_TH = 12'h9C4,
    parameter logic [11:0] LO_TH = 12'h5DC
) (
    // Clock, reset and sensed levels
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [11:0] sense_h,
    input  wire logic [11:0] sense_l,
    // Threshold outputs and conversion starts
    input  wire logic        adc_start_req,
    output logic             comparator_high_threshold_out,
    output logic             comparator_low_threshold_out,
    output logic [7:0]       starts
);
    // Asynchronous to the block
    assign comparator_high_threshold_out = sense_h > HI_TH;
    assign comparator_low_threshold_out  = sense_l < LO_TH;
    // One request starts all channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            starts <= 8'h00;
        end else if (adc_start_req) begin
            starts <= starts + 8'h01;
        end
    end
endmodule
`default_nettype wire

// ==== sim/pfc_trip_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module pfc_trip_assertions
    import pfc_pkg::*;
(
    // Clock, reset, bus and time base
    input wire logic             aclk,
    input wire logic             aresetn,
    input wire logic             s_axi_bvalid,
    input wire logic [CNT_W-1:0] time_base_count,
    input wire logic             updown_mode,
    // Trip path outputs
    input wire logic             chan_a_event0_trip_force,
    input wire logic             chan_a_event1_trip_force,
    input wire logic             chan_b_event0_trip_force,
    input wire logic             chan_b_event1_trip_force,
    input wire logic             chan_a_event0_irq,
    input wire logic             arb_direct_a,
    input wire logic             per_cycle_block,
    input wire logic             one_shot_block,
    input wire logic             trip_block_one_shot,
    input wire logic             adc_start_req
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    wire logic any_f = chan_a_event0_trip_force | chan_a_event1_trip_force
                     | chan_b_event0_trip_force | chan_b_event1_trip_force;
    sequence s_irq_pulse;
        chan_a_event0_irq ##1 !chan_a_event0_irq;
    endsequence
    AST_IRQ_PULSE: assert property ($rose(chan_a_event0_trip_force) |-> s_irq_pulse)
        else $error("irq not one pulse");
    AST_IRQ_CAUSE: assert property (chan_a_event0_irq |-> chan_a_event0_trip_force)
        else $error("irq without force");
    AST_ADC_PULSE: assert property (adc_start_req |=> !adc_start_req)
        else $error("adc start too long");
    AST_ADC_CAUSE: assert property (adc_start_req |-> $past(time_base_count) == TB_ZERO
        && $past(updown_mode))
        else $error("adc start without cause");
    AST_OST_WINS: assert property ($rose(one_shot_block) |-> ##[0:1] trip_block_one_shot)
        else $error("one-shot not given precedence");
    AST_BLOCK_CAUSE: assert property ($rose(per_cycle_block) |-> $past(any_f))
        else $error("per-cycle block without force");
    AST_OST_HOLD: assert property ($fell(one_shot_block) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("one-shot released early");
    AST_ARB_A: assert property ($rose(arb_direct_a) |-> any_f)
        else $error("direct path without force");
endmodule
`default_nettype wire

// ==== sim/pfc_trip_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module pfc_trip_tb_top import pfc_pkg::*;;
    localparam logic [11:0] HI = 12'h9C4, LO = 12'h5DC;
    // Qualifier truth table: nibble per code, bit index {high line, low line}
    localparam logic [31:0] QTBL = 32'h824C_3A50;
    logic aclk = 0, aresetn = 0, updown_mode = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, starts, n0;
    logic [31:0] s_axi_wdata = 0, r = 32'h0c98, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF, ph = 0;
    logic [1:0] ext_trip_in = 0, s_axi_bresp, s_axi_rresp;
    logic [11:0] sense_h = 0, sense_l = 0;
    logic [CNT_W-1:0] time_base_count;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic comparator_high_threshold_out, comparator_low_threshold_out, adc_start_req;
    logic chan_a_event0_trip_force, chan_a_event1_trip_force, chan_b_event0_trip_force;
    logic chan_b_event1_trip_force, chan_a_event0_irq, chan_a_event1_irq, chan_b_event0_irq;
    logic chan_b_event1_irq, arb_direct_a, arb_direct_b, per_cycle_block, one_shot_block;
    logic trip_block, trip_block_one_shot;
    int miscompares = 0, num_checks = 0, cyc = 0;
    logic [33:0] exp_q[$];
    pfc_trip u_dut (.*);
    pfc_comp_model #(.HI_TH(HI), .LO_TH(LO)) u_comp (.*);
    always #25 aclk = ~aclk;
    // Up-down count, period 14 cycles
    always @(posedge aclk) ph <= (ph == 4'd13) ? 4'd0 : ph + 4'd1;
    assign time_base_count = {12'h000, (ph <= 4'd7) ? ph : 4'd14 - ph};
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic complete_run;
        $display("checks %0d, miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] rs = RESP_OKAY);
        exp_q.push_back({rs, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    always @(posedge aclk) if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            complete_run;
        end
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(OFS_QUAL_CFG, 32'h0);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(OFS_TRIP_SEL, 32'h21);
        wr(OFS_TRIP_ACT, 32'h0);
        for (int c = 0; c < 8; c++) begin
            wr(OFS_QUAL_CFG, 32'(c));
            repeat (4) begin
                r = nx(r);
                sense_h <= r[11:0];
                sense_l <= r[23:12];
                repeat (8) @(posedge aclk);
                rd(OFS_STATUS, {29'h0, QTBL[c*4 + int'({r[11:0] > HI, r[23:12] < LO})], 2'h0});
            end
        end
        sense_h <= 12'h000;
        sense_l <= 12'hFFF;
        wr(OFS_FILT_CFG, 32'h8);
        wr(OFS_TRIP_SEL, 32'h25);
        wr(OFS_QUAL_CFG, 32'h4);
        ext_trip_in <= 2'b01;
        repeat (3) @(posedge aclk);
        rd(OFS_STATUS, 32'h0);
        repeat (12) @(posedge aclk);
        rd(OFS_STATUS, 32'h4);
        ext_trip_in <= 2'b00;
        sense_h <= 12'hFFF;
        wr(OFS_TRIP_ACT, 32'h1);
        wr(OFS_BLOCK_EN, 32'h111);
        repeat (8) @(posedge aclk);
        chk(arb_direct_a, 1'b1);
        chk(arb_direct_b, 1'b0);
        chk(one_shot_block, 1'b0);
        wr(OFS_TRIP_ACT, 32'h0);
        n0 = starts;
        repeat (42) @(posedge aclk);
        chk(8'(starts - n0), 8'd3);
        rd(OFS_STATUS, 32'h47);
        chk(trip_block_one_shot, 1'b1);
        sense_h <= 12'h000;
        repeat (20) @(posedge aclk);
        rd(OFS_STATUS, 32'h42);
        wr(OFS_STATUS, 32'h2);
        rd(OFS_STATUS, 32'h0);
        complete_run;
    end
endmodule
bind pfc_trip pfc_trip_assertions u_chk (.*);
`default_nettype wire
